/* verilog/vhc_pkg.sv */
/*
  shared constants for the vacuum hysteresis controller: register map,
  field positions, reset values, led bar scale and timing figures.
  assumes a 100 MHz clock and a sensor that reports vacuum in mbar.
*/
package vhc_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_HZ      = 100_000_000;
  localparam int MS_PER_S         = 1000;
  localparam int SUPPLY_BLIP_MS   = 50;    // length of the supply blink
  localparam int SUPPLY_PERIOD_MS = 1000;  // repeat of the supply blink
  localparam int FLASH_HALF_MS    = 100;   // half period of rapid flash

  // ----------------------------------------------------------------
  // vacuum scale
  // ----------------------------------------------------------------
  localparam int               VAC_W         = 11;
  localparam logic [10:0]      LIMIT_MAX     = 11'h7FF;  // control off
  localparam logic [10:0]      PP_HYST_MBAR  = 11'h00A;  // fixed 10 mbar
  localparam logic [10:0]      CTRL_HYST_DIV = 11'h005;  // one fifth
  localparam int               LED_N         = 8;
  // bar positions in percent, index 0 is the lowest led
  localparam logic [7:0][6:0]  LED_PCT       = {7'h64, 7'h4B, 7'h41, 7'h37,
                                                7'h28, 7'h1E, 7'h14, 7'h0A};
  localparam logic [6:0]       PCT_FULL      = 7'h64;

  // ----------------------------------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG      = 8'h00;
  localparam logic [7:0] OFS_CTRL_LIM = 8'h04;
  localparam logic [7:0] OFS_PP_LIM   = 8'h08;
  localparam logic [7:0] OFS_BLOW_MS  = 8'h0C;
  localparam logic [7:0] OFS_STATUS   = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST   = 8'h14;
  localparam logic [7:0] OFS_IRQ_MSK  = 8'h18;
  localparam logic [7:0] OFS_VACUUM   = 8'h1C;

  // ----------------------------------------------------------------
  // fields and reset values
  // ----------------------------------------------------------------
  localparam int CFG_NC_BIT    = 0;
  localparam int ST_VENTURI    = 0;
  localparam int ST_BLOWOFF    = 1;
  localparam int ST_PART       = 2;
  localparam int ST_OOR        = 3;
  localparam int ST_SUCTION    = 4;
  localparam int IRQ_PP_RISE   = 0;
  localparam int IRQ_PP_FALL   = 1;
  localparam int IRQ_OOR       = 2;
  localparam int IRQ_BLOW_DONE = 3;
  localparam int IRQ_N         = 4;

  localparam logic        CFG_NC_RST   = 1'b1;
  localparam logic [10:0] CTRL_LIM_RST = 11'h226;  // 550 mbar
  localparam logic [10:0] PP_LIM_RST   = 11'h190;  // 400 mbar
  localparam logic [10:0] BLOW_MS_RST  = 11'h000;  // external blow-off
  localparam logic [3:0]  IRQ_MSK_RST  = 4'h0;

endpackage : vhc_pkg

/* verilog/vhc_cmp_if.sv */
/*
  carrier between the top and one hysteresis comparator.
  assumes one clock domain shared by both ends.
*/
`timescale 1ns/1ps
interface vhc_cmp_if #(parameter int W = 11);
  logic [W-1:0] level;    // measured vacuum
  logic [W:0]   on_thr;   // switch on at or above
  logic [W:0]   off_thr;  // switch off below
  logic         enable;   // low clears the state
  logic         active;   // comparator state

  modport ctrl (output level, output on_thr, output off_thr, output enable, input active);
  modport cmp  (input level, input on_thr, input off_thr, input enable, output active);
endinterface : vhc_cmp_if

/* verilog/vhc_hyst.sv */
/*
  two-threshold comparator with a held state.
  assumes thresholds are stable for at least one cycle around a change.
*/
`timescale 1ns/1ps
module vhc_hyst
  import vhc_pkg::*;
#(
  parameter int W = 11
) (
  input  wire logic  clk,     // system clock
  input  wire logic  arst_n,  // async reset, active low
  vhc_cmp_if.cmp     cmp      // thresholds in, state out
);

  typedef struct packed {
    logic active;
  } vhc_hyst_s;

  vhc_hyst_s q;
  vhc_hyst_s d;

  // ----------------------------------------------------------------
  // state update
  // ----------------------------------------------------------------
  // set and clear never overlap because the held state picks one test
  always_comb begin
    d = q;
    if (!cmp.enable) begin
      d.active = 1'b0;
    end else if (q.active) begin
      if ({1'b0, cmp.level} < cmp.off_thr) d.active = 1'b0;
    end else begin
      if ({1'b0, cmp.level} >= cmp.on_thr) d.active = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) q <= '0;
    else q <= d;
  end

  assign cmp.active = q.active;

endmodule : vhc_hyst

/* verilog/vhc_top.sv */
/*
  vacuum hysteresis controller: air-saving control of vacuum generation,
  part-present output, blow-off timing and the led bar, with an apb slave.
  assumes command inputs and the vacuum sample are synchronous to clk.
*/
// Notes on behaviour
// RULE1: generation stops once vacuum reaches the control limit.
// RULE2: after stopping, generation restarts when vacuum falls below limit minus hysteresis.
// RULE3: a control limit at its maximum disables control and keeps generation on during suction.
// RULE4: when no bar led is lit the full-scale led blinks briefly to show supply.
// RULE5: the single part-present output is active high and cannot be inverted.
// RULE6: part-present sets above its limit and clears below the lower limit.
// RULE7: the led bar shows vacuum as a percentage of the maximum vacuum.
// RULE8: out-of-range vacuum flashes the end led rapidly, the 10% led for overpressure.
// RULE9: the controller drives suction and blow-off commands and gets part-present back.
// RULE10: control hysteresis is one fifth of the control limit.
// RULE11: part-present hysteresis is a fixed 10 mbar below its limit.
// RULE12: normally-closed variant turns generation on with suction, normally-open turns it off.
// RULE13: a nonzero blow-off time gives timed blow-off on leaving suction, else blow-off follows its input.
// RULE14: without suction generation stays off and control state is cleared.
`timescale 1ns/1ps
module vhc_top
  import vhc_pkg::*;
#(
  parameter int          CYC_PER_MS   = CLK_FREQ_HZ / MS_PER_S,
  parameter logic [10:0] MAX_VAC_MBAR = 11'h384
) (
  input  wire logic               clk,                    // system clock
  input  wire logic               arst_n,                 // async reset, active low
  input  wire logic               psel,                   // apb select
  input  wire logic               penable,                // apb enable
  input  wire logic               pwrite,                 // apb direction
  input  wire logic [7:0]         paddr,                  // apb byte address
  input  wire logic [31:0]        pwdata,                 // apb write data
  output logic      [31:0]        prdata,                 // apb read data
  output logic                    pready,                 // apb ready
  output logic                    pslverr,                // apb error
  input  wire logic               suction_command_input,  // suction command
  input  wire logic               blowoff_command_input,  // blow-off command
  input  wire logic signed [11:0] vacuum_mbar,            // sensor, negative is overpressure
  output logic                    venturi_on,             // vacuum generation valve
  output logic                    blowoff_valve,          // blow-off valve
  output logic                    part_present,           // part-present output
  output logic      [LED_N-1:0]   led_bar,                // bar leds, bit 0 is 10%
  output logic                    irq                     // level interrupt
);

  localparam int MS_W = $clog2(CYC_PER_MS + 1);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              pready;
    logic              pslverr;
    logic [31:0]       prdata;
    logic              nc;
    logic [10:0]       ctrl_lim;
    logic [10:0]       pp_lim;
    logic [10:0]       blow_ms;
    logic [IRQ_N-1:0]  irq_st;
    logic [IRQ_N-1:0]  irq_msk;
    logic              irq;
    logic              suct_prev;
    logic              pp_prev;
    logic              oor_prev;
    logic [10:0]       blow_cnt;
    logic              blow_on;
    logic              venturi;
    logic [MS_W-1:0]   ms_cnt;
    logic              ms_tick;
    logic [9:0]        sup_cnt;
    logic [9:0]        flash_cnt;
    logic              flash_ph;
    logic [LED_N-1:0]  led;
  } vhc_top_s;

  vhc_top_s q;
  vhc_top_s d;

  // ----------------------------------------------------------------
  // comparators
  // ----------------------------------------------------------------
  vhc_cmp_if #(.W(VAC_W)) ctl_if ();
  vhc_cmp_if #(.W(VAC_W)) pp_if ();

  vhc_hyst #(.W(VAC_W)) u_ctl (
    .clk    (clk),
    .arst_n (arst_n),
    .cmp    (ctl_if.cmp)
  );

  vhc_hyst #(.W(VAC_W)) u_pp (
    .clk    (clk),
    .arst_n (arst_n),
    .cmp    (pp_if.cmp)
  );

  logic        suct;
  logic        ctrl_dis;
  logic        over_p;
  logic        oor;
  logic [10:0] vac_pos;
  logic [10:0] ctrl_off;
  logic [10:0] pp_off;

  // input conditioning and thresholds
  always_comb begin
    suct     = q.nc ? suction_command_input : ~suction_command_input;  // [RULE12]
    ctrl_dis = (q.ctrl_lim == LIMIT_MAX);                               // [RULE3]
    over_p   = vacuum_mbar[11];
    vac_pos  = over_p ? 11'h000 : vacuum_mbar[10:0];
    oor      = over_p || (vac_pos > MAX_VAC_MBAR);
    ctrl_off = q.ctrl_lim - (q.ctrl_lim / CTRL_HYST_DIV);               // [RULE10]
    pp_off   = (q.pp_lim > PP_HYST_MBAR) ? (q.pp_lim - PP_HYST_MBAR) : 11'h000;  // [RULE11]
  end

  // control comparator: stop at the limit, restart below the hysteresis
  assign ctl_if.level   = vac_pos;
  assign ctl_if.on_thr  = {1'b0, q.ctrl_lim};             // [RULE1]
  assign ctl_if.off_thr = {1'b0, ctrl_off};               // [RULE2]
  assign ctl_if.enable  = suct && !ctrl_dis;              // [RULE14]

  // part-present comparator: strictly above the limit to set
  assign pp_if.level    = vac_pos;
  assign pp_if.on_thr   = {1'b0, q.pp_lim} + 12'h001;     // [RULE6]
  assign pp_if.off_thr  = {1'b0, pp_off};                 // [RULE6]
  assign pp_if.enable   = 1'b1;

  // ----------------------------------------------------------------
  // apb read mux
  // ----------------------------------------------------------------
  logic [31:0] rd_val;
  logic        hit;
  logic [4:0]  stat;

  always_comb begin
    stat        = '0;
    stat[ST_VENTURI] = q.venturi;
    stat[ST_BLOWOFF] = q.blow_on;
    stat[ST_PART]    = pp_if.active;
    stat[ST_OOR]     = oor;
    stat[ST_SUCTION] = suct;
    hit    = 1'b1;
    rd_val = '0;
    unique case (paddr)
      OFS_CFG:      rd_val[CFG_NC_BIT] = q.nc;
      OFS_CTRL_LIM: rd_val[10:0] = q.ctrl_lim;
      OFS_PP_LIM:   rd_val[10:0] = q.pp_lim;
      OFS_BLOW_MS:  rd_val[10:0] = q.blow_ms;
      OFS_STATUS:   rd_val[4:0] = stat;
      OFS_IRQ_ST:   rd_val[IRQ_N-1:0] = q.irq_st;
      OFS_IRQ_MSK:  rd_val[IRQ_N-1:0] = q.irq_msk;
      OFS_VACUUM:   rd_val[11:0] = vacuum_mbar;
      default:      hit = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  logic             access;
  logic             wr;
  logic             susp_fall;
  logic [IRQ_N-1:0] ev;
  logic             any_led;
  logic [19:0]      scaled;
  logic [19:0]      level_i;

  always_comb begin
    d         = q;
    access    = psel && penable;
    wr        = access && q.pready && pwrite && hit;
    susp_fall = q.suct_prev && !suct;
    ev        = '0;
    scaled    = 20'(vac_pos) * 20'(PCT_FULL);
    level_i   = '0;
    any_led   = 1'b0;

    // apb: answer one cycle into the access phase
    d.pready = access && !q.pready;
    if (access && !q.pready) begin
      d.prdata  = (hit && !pwrite) ? rd_val : 32'h0000_0000;
      d.pslverr = !hit;
    end else begin
      d.pslverr = 1'b0;
    end

    // writes land on the edge that sees pready high
    if (wr) begin
      unique case (paddr)
        OFS_CFG:      d.nc = pwdata[CFG_NC_BIT];
        OFS_CTRL_LIM: d.ctrl_lim = pwdata[10:0];
        OFS_PP_LIM:   d.pp_lim = pwdata[10:0];
        OFS_BLOW_MS:  d.blow_ms = pwdata[10:0];
        OFS_IRQ_MSK:  d.irq_msk = pwdata[IRQ_N-1:0];
        default:      d.irq_msk = q.irq_msk;
      endcase
    end

    // millisecond tick shared by all timers
    d.ms_tick = 1'b0;
    if (q.ms_cnt == MS_W'(CYC_PER_MS - 1)) begin
      d.ms_cnt  = '0;
      d.ms_tick = 1'b1;
    end else begin
      d.ms_cnt = q.ms_cnt + MS_W'(1);
    end

    // vacuum generation with air saving
    d.venturi   = suct && (ctrl_dis || !ctl_if.active);  // [RULE1] [RULE3] [RULE14]
    d.suct_prev = suct;

    // blow-off: timed on leaving suction, else follow the input
    if (q.blow_ms != 11'h000) begin
      if (suct) begin
        d.blow_on  = 1'b0;
        d.blow_cnt = '0;
      end else if (susp_fall) begin
        d.blow_on  = 1'b1;                               // [RULE13]
        d.blow_cnt = q.blow_ms;
      end else if (q.blow_on && q.ms_tick) begin
        d.blow_cnt = q.blow_cnt - 11'h001;
        if (q.blow_cnt == 11'h001) begin
          d.blow_on = 1'b0;
          ev[IRQ_BLOW_DONE] = 1'b1;
        end
      end
    end else begin
      d.blow_on  = blowoff_command_input && !suct;       // [RULE13]
      d.blow_cnt = '0;
    end

    // events into sticky status
    d.pp_prev  = pp_if.active;
    d.oor_prev = oor;
    ev[IRQ_PP_RISE] = pp_if.active && !q.pp_prev;
    ev[IRQ_PP_FALL] = !pp_if.active && q.pp_prev;
    ev[IRQ_OOR]     = oor && !q.oor_prev;
    // a new event beats a write-one-to-clear in the same cycle
    if (wr && paddr == OFS_IRQ_ST) begin
      d.irq_st = (q.irq_st & ~pwdata[IRQ_N-1:0]) | ev;
    end else begin
      d.irq_st = q.irq_st | ev;
    end
    d.irq = |(d.irq_st & d.irq_msk);

    // supply blink and rapid flash timebases
    if (q.ms_tick) begin
      d.sup_cnt = (q.sup_cnt == 10'(SUPPLY_PERIOD_MS - 1)) ? 10'h000 : q.sup_cnt + 10'h001;
      if (q.flash_cnt == 10'(FLASH_HALF_MS - 1)) begin
        d.flash_cnt = 10'h000;
        d.flash_ph  = !q.flash_ph;
      end else begin
        d.flash_cnt = q.flash_cnt + 10'h001;
      end
    end

    // bar as a fraction of the maximum vacuum
    for (int i = 0; i < LED_N; i++) begin
      level_i  = 20'(MAX_VAC_MBAR) * 20'(LED_PCT[i]);
      d.led[i] = (scaled >= level_i) && (scaled != 20'h00000);  // [RULE7]
      any_led  = any_led | d.led[i];
    end
    if (over_p) begin
      d.led    = '0;
      d.led[0] = q.flash_ph;                              // [RULE8]
    end else if (oor) begin
      d.led[LED_N-1] = q.flash_ph;                        // [RULE8]
    end else if (!any_led) begin
      d.led[LED_N-1] = (q.sup_cnt < 10'(SUPPLY_BLIP_MS)); // [RULE4]
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      q          <= '0;
      q.nc       <= CFG_NC_RST;
      q.ctrl_lim <= CTRL_LIM_RST;
      q.pp_lim   <= PP_LIM_RST;
      q.blow_ms  <= BLOW_MS_RST;
      q.irq_msk  <= IRQ_MSK_RST;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // outputs, all from flops
  // ----------------------------------------------------------------
  assign prdata        = q.prdata;
  assign pready        = q.pready;
  assign pslverr       = q.pslverr;
  assign venturi_on    = q.venturi;
  assign blowoff_valve = q.blow_on;
  assign part_present  = pp_if.active;  // fixed active-high sense [RULE5] [RULE9]
  assign led_bar       = q.led;
  assign irq           = q.irq;

endmodule : vhc_top

/* testbench/vhc_top_props.sv */
/*
  concurrent checks on the vacuum hysteresis controller ports.
  assumes a bind to vhc_top.
*/
`timescale 1ns/1ps
module vhc_top_props
  import vhc_pkg::*;
#(
  parameter logic [10:0] MAX_VAC_MBAR = 11'h384
) (
  input wire logic               clk,                    // clock
  input wire logic               arst_n,                 // reset, active low
  input wire logic               psel,                   // apb select
  input wire logic               penable,                // apb enable
  input wire logic               pwrite,                 // apb direction
  input wire logic [7:0]         paddr,                  // apb address
  input wire logic [31:0]        pwdata,                 // apb write data
  input wire logic               pready,                 // apb ready
  input wire logic               pslverr,                // apb error
  input wire logic               suction_command_input,  // suction command
  input wire logic               blowoff_command_input,  // blow-off command
  input wire logic signed [11:0] vacuum_mbar,            // sensor value
  input wire logic               venturi_on,             // generation valve
  input wire logic               blowoff_valve,          // blow-off valve
  input wire logic               part_present,           // part-present output
  input wire logic [LED_N-1:0]   led_bar                 // bar leds
);
  // ----------------------------------------------------------------
  // register shadows and derived levels
  // ----------------------------------------------------------------
  localparam int PPL = PP_LIM_RST;
  logic        nc_q;
  logic [10:0] lim_q;
  logic        blow0_q;
  int          v;
  int          lim;
  logic        suc;
  logic [6:0]  bar_exp;
  assign v   = vacuum_mbar;
  assign lim = lim_q;
  assign suc = nc_q ? suction_command_input : !suction_command_input;

  // follow completed writes
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      nc_q    <= CFG_NC_RST;
      lim_q   <= CTRL_LIM_RST;
      blow0_q <= 1'b1;
    end else if (psel && penable && pready && pwrite) begin
      if (paddr == OFS_CFG) nc_q <= pwdata[CFG_NC_BIT];
      if (paddr == OFS_CTRL_LIM) lim_q <= pwdata[10:0];
      if (paddr == OFS_BLOW_MS) blow0_q <= (pwdata[10:0] == 11'h000);
    end
  end

  // lower seven bar leds
  always_comb begin
    for (int i = 0; i < 7; i++) begin
      bar_exp[i] = (v > 0) && (v * 100 >= int'(MAX_VAC_MBAR) * int'(LED_PCT[i]));
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  gen_stop_a: assert property ((suc && v >= lim && lim_q != LIMIT_MAX) [*3] |=> !venturi_on)
    else $error("venturi on at limit");
  gen_restart_a: assert property ((suc && v < lim - lim / 5) [*3] |=> venturi_on)
    else $error("venturi off below restart");
  ctrl_off_a: assert property ((suc && lim_q == LIMIT_MAX) [*3] |=> venturi_on)
    else $error("venturi off, control off");
  idle_off_a: assert property ((!suc) [*3] |=> !venturi_on)
    else $error("venturi on idle");
  part_set_a: assert property ((v > PPL) [*2] |=> part_present)
    else $error("part low above limit");
  part_clr_a: assert property ((v < PPL - 10) [*2] |=> !part_present)
    else $error("part high below limit");
  blow_ext_a: assert property ((blow0_q && blowoff_command_input && !suc) [*3] |=> blowoff_valve)
    else $error("blow-off not following");
  bar_level_a: assert property (($stable(vacuum_mbar) && v > 0 && v <= MAX_VAC_MBAR) [*3] |-> led_bar[6:0] == bar_exp)
    else $error("bar mismatch");
  over_led_a: assert property ((v < 0) [*3] |-> led_bar[7:1] == 7'h00)
    else $error("bar lit at overpressure");
  apb_ready_a: assert property ((psel && !penable) |-> ##2 pready)
    else $error("apb answer late");
endmodule : vhc_top_props

/* testbench/vhc_ctrl_model.sv */
/*
  machine controller model: suction and blow-off commands.
  assumes the block's clock; commands change after an edge.
*/
`timescale 1ns/1ps
module vhc_ctrl_model (
  input  wire logic clk,           // system clock
  input  wire logic part_present,  // feedback from the block
  output logic      suction_cmd,   // suction command
  output logic      blowoff_cmd    // blow-off command
);
  initial begin
    suction_cmd = 1'b0;
    blowoff_cmd = 1'b0;
  end

  // lag models a slow controller
  task automatic drive(input logic s, input logic b, input int lag);
    repeat (lag + 1) @(posedge clk);
    suction_cmd <= s;
    blowoff_cmd <= b;
  endtask : drive

  // bounded wait on the feedback level
  task automatic wait_part(input logic lvl, output logic seen);
    int n;
    n = 0;
    while (part_present !== lvl && n < 20) begin
      @(posedge clk);
      n++;
    end
    seen = (part_present === lvl);
  endtask : wait_part
endmodule : vhc_ctrl_model

/* testbench/vhc_top_tb.sv */
/*
  self-checking bench for the vacuum controller.
  assumes the package, design and partner model compile first.
*/
`timescale 1ns/1ps
module vhc_top_tb;
  import vhc_pkg::*;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  localparam int CPM = 10;  // short ms keeps the run brief
  logic               clk = 1'b0;
  logic               arst_n = 1'b0;
  logic               psel = 1'b0;
  logic               penable = 1'b0;
  logic               pwrite = 1'b0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0;
  logic [31:0]        prdata;
  logic               pready;
  logic               pslverr;
  logic               suction_command_input;
  logic               blowoff_command_input;
  logic signed [11:0] vacuum_mbar = 12'sh000;
  logic               venturi_on;
  logic               blowoff_valve;
  logic               part_present;
  logic [LED_N-1:0]   led_bar;
  logic               irq;
  int                 error_cnt = 0;
  int                 num_checks = 0;

  vhc_top #(.CYC_PER_MS(CPM)) dut (.*);
  vhc_ctrl_model u_ctrl (.clk(clk), .part_present(part_present),
    .suction_cmd(suction_command_input), .blowoff_cmd(blowoff_command_input));

  always #5 clk = ~clk;

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic chb(input string nm, input logic e, input logic g);
    chk(nm, {31'h0, e}, {31'h0, g});
  endtask : chb
  // one apb transfer, held until pready
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    int n;
    n = 0;
    @(posedge clk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    chb("pready", 1'b1, pready);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'b0, a, 32'h0, r, e);
  endtask : rd
  task automatic setv(input logic [11:0] v);
    @(posedge clk);
    vacuum_mbar <= v;
    cyc(4);
  endtask : setv
  // count cycles lit, quiet leds dark
  task automatic watch(input int bi, input int len, input logic [7:0] quiet, output int n);
    logic bad;
    n = 0;
    bad = 1'b0;
    repeat (len) begin
      @(posedge clk);
      n += int'(led_bar[bi] === 1'b1);
      bad |= ((led_bar & quiet) != 8'h00);
    end
    chb("led_quiet", 1'b0, bad);
  endtask : watch

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    logic [7:0]  ad [7] = '{OFS_CFG, OFS_CTRL_LIM, OFS_PP_LIM, OFS_BLOW_MS, OFS_IRQ_ST, OFS_IRQ_MSK, 8'h20};
    logic [31:0] ex [7] = '{32'h1, 32'h226, 32'h190, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 7; i++) begin
      apb(1'b0, ad[i], 32'h0, r, e);
      chk("reg_value", ex[i], r);
      chb("reg_error", i == 6, e);
    end
    wr(OFS_STATUS, 32'h1F);
    rd(OFS_STATUS, r);
    chk("status_ro", 32'h0, r);
  endtask : t_regs

  // stop at limit, restart below it minus a fifth
  task automatic t_control();
    logic [11:0] vs [5] = '{12'h000, 12'h225, 12'h226, 12'h1B8, 12'h1B7};
    logic        ex [5] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b1};
    logic [31:0] r;
    u_ctrl.drive(1'b1, 1'b0, 0);
    for (int i = 0; i < 5; i++) begin
      setv(vs[i]);
      chb("venturi", ex[i], venturi_on);
    end
    rd(OFS_STATUS, r);
    chk("status", 32'h15, r);
    wr(OFS_CTRL_LIM, 32'h7FF);
    setv(12'h370);
    chb("venturi", 1'b1, venturi_on);
    wr(OFS_CTRL_LIM, 32'h226);
    setv(12'h370);
    chb("venturi", 1'b0, venturi_on);
  endtask : t_control

  // inverted sense; generation runs while the suction command input is low
  task automatic t_novariant();
    wr(OFS_CFG, 32'h0);
    setv(12'h1F4);
    chb("venturi", 1'b0, venturi_on);
    u_ctrl.drive(1'b0, 1'b0, 0);
    cyc(4);
    chb("venturi", 1'b1, venturi_on);
    u_ctrl.drive(1'b1, 1'b0, 3);
    cyc(4);
    chb("venturi", 1'b0, venturi_on);
    wr(OFS_CFG, 32'h1);
    u_ctrl.drive(1'b0, 1'b0, 0);
  endtask : t_novariant

  task automatic t_part();
    logic [31:0] r;
    logic        s;
    setv(12'h000);
    wr(OFS_IRQ_ST, 32'hF);
    wr(OFS_IRQ_MSK, 32'h1);
    setv(12'h190);
    chb("part", 1'b0, part_present);
    setv(12'h191);
    u_ctrl.wait_part(1'b1, s);
    chb("part", 1'b1, s);
    chb("irq", 1'b1, irq);
    wr(OFS_IRQ_ST, 32'h1);
    cyc(2);
    chb("irq", 1'b0, irq);
    setv(12'h186);
    chb("part", 1'b1, part_present);
    setv(12'h185);
    chb("part", 1'b0, part_present);
    chb("irq", 1'b0, irq);
    rd(OFS_IRQ_ST, r);
    chk("irq_status", 32'h2, r);
    wr(OFS_IRQ_ST, 32'h2);
    wr(OFS_IRQ_MSK, 32'h0);
  endtask : t_part

  task automatic t_blow();
    logic [31:0] r;
    int          n;
    u_ctrl.drive(1'b0, 1'b1, 0);
    cyc(4);
    chb("blowoff", 1'b1, blowoff_valve);
    u_ctrl.drive(1'b1, 1'b1, 0);
    cyc(4);
    chb("blowoff", 1'b0, blowoff_valve);
    wr(OFS_BLOW_MS, 32'h2);
    u_ctrl.drive(1'b0, 1'b0, 0);
    cyc(4);
    n = 0;
    while (blowoff_valve === 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    chb("blow_len", 1'b1, n >= CPM - 4 && n <= 2 * CPM);
    rd(OFS_IRQ_ST, r);
    chk("blow_done", 32'h8, r & 32'h8);
    wr(OFS_IRQ_ST, 32'hF);
    wr(OFS_BLOW_MS, 32'h0);
  endtask : t_blow

  task automatic t_leds();
    int n;
    setv(12'h1EF);
    chk("bar", 32'h1F, {25'h0, led_bar[6:0]});
    setv(12'h1EE);
    chk("bar", 32'h0F, {25'h0, led_bar[6:0]});
    setv(12'hFFB);
    watch(0, 2 * FLASH_HALF_MS * CPM, 8'hFE, n);
    chb("flash", 1'b1, n >= (FLASH_HALF_MS - 1) * CPM && n <= (FLASH_HALF_MS + 1) * CPM);
    setv(12'h3E8);
    watch(7, 2 * FLASH_HALF_MS * CPM, 8'h00, n);
    chb("oor", 1'b1, n >= (FLASH_HALF_MS - 1) * CPM && n <= (FLASH_HALF_MS + 1) * CPM);
    setv(12'h000);
    watch(7, SUPPLY_PERIOD_MS * CPM, 8'h7F, n);
    chb("supply", 1'b1, n >= (SUPPLY_BLIP_MS - 1) * CPM && n <= (SUPPLY_BLIP_MS + 1) * CPM);
  endtask : t_leds

  task automatic results();
    $display("checks %0d errors %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  // 16-cycle reset, then scenarios
  initial begin
    cyc(16);
    arst_n <= 1'b1;
    t_regs();
    t_control();
    t_novariant();
    t_part();
    t_blow();
    t_leds();
    results();
  end

  // watchdog far past the run
  initial begin
    #1_000_000;
    error_cnt++;
    results();
  end
endmodule : vhc_top_tb

bind vhc_top vhc_top_props #(.MAX_VAC_MBAR(MAX_VAC_MBAR)) u_props (.*);
